// file: eeprom_pkg.sv
`default_nettype none

package eeprom_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned F_SCL_KHZ     = 400;
  // quarter of an scl period, rounded up so the bus never runs fast
  localparam int unsigned SCL_QTR_CYC   = (1000000 + F_SCL_KHZ * 4 * CLK_PERIOD_NS - 1) / (F_SCL_KHZ * 4 * CLK_PERIOD_NS);
  localparam int unsigned DIV_W         = 7;
  localparam int unsigned T_WR_MS       = 5;
  localparam int unsigned WR_CYC        = T_WR_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned WR_CNT_W      = 20;

  // ----------------------------------------------------------------
  // addressing and array layout
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE     = 4'hA;
  localparam logic [2:0] DEV_SEL_LOW  = 3'h0;
  localparam logic       RW_READ      = 1'b1;
  localparam logic       RW_WRITE     = 1'b0;
  localparam int unsigned MEM_BYTES   = 256;
  localparam int unsigned PAGE_BYTES  = 16;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam int unsigned LEN_W       = 9;

  // ----------------------------------------------------------------
  // master commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_WRITE,
    OP_READ_CUR,
    OP_READ_RAND,
    OP_POLL
  } op_t;

endpackage

`default_nettype wire

// file: i2c_if.sv
`timescale 1ns/1ps
`default_nettype none

interface i2c_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;

  // open-drain wired-and with pull-up
  assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport device (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface

`default_nettype wire

// file: eeprom_slave.sv
`timescale 1ns/1ps
`default_nettype none

module eeprom_slave #(
  parameter int unsigned WR_CYCLES = eeprom_pkg::WR_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sup_reset,
  i2c_if.device     bus,
  output var  logic prog_busy
);
  import eeprom_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_AACK,
    S_MADR,
    S_MACK,
    S_WDAT,
    S_WACK,
    S_RDAT,
    S_RACK
  } dstate_t;

  dstate_t                  state;
  logic [3:0]               cnt;
  logic [7:0]               shreg;
  logic                     oe_n;
  logic                     ack_rx;
  logic [7:0]               ptr;
  logic [PAGE_BYTES-1:0]    page_valid;
  logic [WR_CNT_W-1:0]      timer;
  logic [7:0]               mem      [MEM_BYTES];
  logic [7:0]               page_buf [PAGE_BYTES];
  logic [1:0]               scl_sync;
  logic [1:0]               sda_sync;
  logic [1:0]               sup_sync;
  logic                     scl_d;
  logic                     sda_d;

  // ----------------------------------------------------------------
  // pin synchronisers and bus condition detection
  // ----------------------------------------------------------------
  // two flops per pin, then one more stage on scl and sda for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sup_sync <= 2'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      sup_sync <= {sup_sync[0], sup_reset};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  wire scl_s      = scl_sync[1];
  wire sda_s      = sda_sync[1];
  wire sup_s      = sup_sync[1];
  wire scl_rise   = scl_s & ~scl_d;
  wire scl_fall   = ~scl_s & scl_d;
  wire start_det  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det   = scl_s & scl_d & ~sda_d & sda_s;
  wire ev_ok      = ~sup_s & ~stop_det & ~start_det;
  wire addr_match = (shreg[7:4] == DEV_TYPE);
  wire rw_read    = (shreg[0] == RW_READ);
  wire byte_end   = scl_fall & (cnt == BYTE_BITS);
  wire byte_in    = ev_ok & byte_end & ((state == S_MADR) | (state == S_WDAT));
  wire load_rd    = ev_ok & scl_fall & (((state == S_AACK) & rw_read) | ((state == S_RACK) & ack_rx));
  wire [7:0] rd_byte = mem[ptr];
  wire commit     = prog_busy & (timer == WR_CNT_W'(WR_CYCLES - 1));
  wire prog_start = ev_ok ? 1'b0 : (stop_det & ~sup_s & ~prog_busy & (|page_valid));

  assign bus.d_sda_o    = 1'b0;
  assign bus.d_sda_oe_n = oe_n;

  // ----------------------------------------------------------------
  // serial protocol state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= S_IDLE;
      cnt    <= 4'h0;
      shreg  <= 8'h00;
      oe_n   <= 1'b1;
      ack_rx <= 1'b0;
    end else if (sup_s) begin
      state <= S_IDLE;
      oe_n  <= 1'b1;
    end else if (stop_det) begin
      state <= S_IDLE;
      oe_n  <= 1'b1;
    end else if (start_det) begin
      state <= prog_busy ? S_IDLE : S_ADDR;
      cnt   <= 4'h0;
      oe_n  <= 1'b1;
    end else begin
      unique case (state)
        S_IDLE: begin
        end
        S_ADDR, S_MADR, S_WDAT: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            cnt   <= cnt + 4'h1;
          end else if (byte_end) begin
            cnt <= 4'h0;
            if (state != S_ADDR || addr_match) begin
              oe_n  <= 1'b0;
              state <= (state == S_ADDR) ? S_AACK : (state == S_MADR) ? S_MACK : S_WACK;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_AACK, S_MACK, S_WACK: begin
          if (scl_fall) begin
            if (state == S_AACK && rw_read) begin
              state <= S_RDAT;
              shreg <= rd_byte;
              oe_n  <= rd_byte[7];
            end else begin
              oe_n  <= 1'b1;
              state <= (state == S_AACK) ? S_MADR : S_WDAT;
            end
          end
        end
        S_RDAT: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == BYTE_BITS) begin
              oe_n  <= 1'b1;
              cnt   <= 4'h0;
              state <= S_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              oe_n  <= shreg[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            ack_rx <= ~sda_s;
          end else if (scl_fall) begin
            if (ack_rx) begin
              state <= S_RDAT;
              shreg <= rd_byte;
              oe_n  <= rd_byte[7];
            end else begin
              state <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // address counter and page bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr        <= 8'h00;
      page_valid <= '0;
    end else begin
      if (load_rd) begin
        ptr <= ptr + 8'h01;
      end else if (byte_in && state == S_MADR) begin
        ptr        <= shreg;
        page_valid <= '0;
      end else if (byte_in) begin
        page_valid[ptr[3:0]] <= 1'b1;
        ptr <= {ptr[7:4], ptr[3:0] + 4'h1};
      end
      if (commit || (sup_s && !prog_busy)) begin
        page_valid <= '0;
      end
    end
  end

  // page buffer capture and single-cycle commit to the array
  always_ff @(posedge clk) begin
    if (byte_in && state == S_WDAT) begin
      page_buf[ptr[3:0]] <= shreg;
    end
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (commit && page_valid[i]) begin
        mem[{ptr[7:4], 4'(i)}] <= page_buf[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // programming cycle timer
  // ----------------------------------------------------------------
  // an active supervisor reset cannot stop a cycle already running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_busy <= 1'b0;
      timer     <= '0;
    end else if (prog_start) begin
      prog_busy <= 1'b1;
      timer     <= '0;
    end else if (commit) begin
      prog_busy <= 1'b0;
    end else if (prog_busy) begin
      timer <= timer + 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: eeprom_master.sv
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign out_data = store[rd_ptr];

  // pointers, fill level and registered flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count     <= next_count;
      in_ready  <= (next_count != (AW+1)'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (push) store[wr_ptr] <= in_data;
  end
endmodule

module eeprom_master (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  i2c_if.master                            bus,
  input  wire logic                        cmd_valid,
  output var  logic                        cmd_ready,
  input  wire eeprom_pkg::op_t             cmd_op,
  input  wire logic [7:0]                  cmd_addr,
  input  wire logic [eeprom_pkg::LEN_W-1:0] cmd_len,
  input  wire logic                        wr_valid,
  output wire logic                        wr_ready,
  input  wire logic [7:0]                  wr_data,
  output var  logic                        rd_valid,
  output var  logic [7:0]                  rd_data,
  output var  logic                        done,
  output var  logic                        nack
);
  import eeprom_pkg::*;

  typedef enum logic [3:0] {
    P_IDLE,
    P_START,
    P_DEVW,
    P_MADDR,
    P_DATA,
    P_RSTART,
    P_DEVR,
    P_RX,
    P_STOP
  } phase_t;

  phase_t           phase;
  op_t              op;
  logic [7:0]       addr;
  logic [LEN_W-1:0] remain;
  logic [DIV_W-1:0] div;
  logic [1:0]       q;
  logic [3:0]       bit_cnt;
  logic [7:0]       sh;
  logic             scl;
  logic             oe_n;
  logic             ack_in;
  logic [1:0]       sda_sync;
  logic             f_valid;
  logic [7:0]       f_data;
  logic             f_pop;
  phase_t           eff_next;

  // ----------------------------------------------------------------
  // write data buffer
  // ----------------------------------------------------------------
  byte_fifo #(.WIDTH(8), .DEPTH(4)) byte_fifo_i (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  // ----------------------------------------------------------------
  // sequencing decode
  // ----------------------------------------------------------------
  function automatic phase_t after(input phase_t p, input op_t o, input logic last);
    unique case (p)
      P_START:  after = (o == OP_READ_CUR) ? P_DEVR : P_DEVW;
      P_DEVW:   after = (o == OP_POLL) ? P_STOP : P_MADDR;
      P_MADDR:  after = (o == OP_WRITE) ? P_DATA : P_RSTART;
      P_DATA:   after = last ? P_STOP : P_DATA;
      P_RSTART: after = P_DEVR;
      P_DEVR:   after = P_RX;
      P_RX:     after = last ? P_STOP : P_RX;
      default:  after = P_IDLE;
    endcase
  endfunction

  wire    tick      = (div == DIV_W'(SCL_QTR_CYC - 1));
  wire    is_cond   = (phase == P_START) | (phase == P_RSTART);
  wire    is_stop   = (phase == P_STOP);
  wire    is_rx     = (phase == P_RX);
  wire    is_byte   = ~is_cond & ~is_stop;
  wire    last      = (remain == LEN_W'(1));
  wire    sda_s     = sda_sync[1];
  wire    phase_end = (q == 2'h3) & (~is_byte | (bit_cnt == BYTE_BITS));
  wire    tx_nack   = is_byte & ~is_rx & ~ack_in;
  assign eff_next   = tx_nack ? P_STOP : after(phase, op, last);
  wire    stall     = phase_end & (eff_next == P_DATA) & ~f_valid;
  wire    advance   = (phase != P_IDLE) & tick & ~stall;
  assign f_pop      = advance & phase_end & (eff_next == P_DATA);
  wire [7:0] next_sh = (eff_next == P_DEVW)  ? {DEV_TYPE, DEV_SEL_LOW, RW_WRITE} :
                       (eff_next == P_DEVR)  ? {DEV_TYPE, DEV_SEL_LOW, RW_READ} :
                       (eff_next == P_MADDR) ? addr :
                       (eff_next == P_DATA)  ? f_data : 8'hFF;

  assign bus.scl        = scl;
  assign bus.m_sda_o    = 1'b0;
  assign bus.m_sda_oe_n = oe_n;

  // sda synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sda_sync <= 2'h3;
    else sda_sync <= {sda_sync[0], bus.sda};
  end

  // ----------------------------------------------------------------
  // bus sequencer: four quarters per bit, start or stop
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= P_IDLE; op <= OP_WRITE; addr <= 8'h00; remain <= '0;
      div <= '0; q <= 2'h0; bit_cnt <= 4'h0; sh <= 8'h00;
      scl <= 1'b1; oe_n <= 1'b1; ack_in <= 1'b0;
      cmd_ready <= 1'b1; done <= 1'b0; nack <= 1'b0;
      rd_valid <= 1'b0; rd_data <= 8'h00;
    end else begin
      done     <= 1'b0;
      rd_valid <= 1'b0;
      if (phase == P_IDLE) begin
        if (cmd_valid && cmd_ready) begin
          phase <= P_START; op <= cmd_op; addr <= cmd_addr; remain <= cmd_len;
          cmd_ready <= 1'b0; nack <= 1'b0; div <= '0; q <= 2'h0; bit_cnt <= 4'h0;
        end
      end else begin
        div <= tick ? '0 : div + 1'b1;
        if (advance) begin
          q <= q + 2'h1;
          unique case (q)
            2'h0: begin
              if (is_cond) oe_n <= 1'b1;
              else if (is_stop) oe_n <= 1'b0;
              else if (bit_cnt != BYTE_BITS) oe_n <= is_rx | sh[7];
              else oe_n <= ~is_rx | last;
            end
            2'h1: scl <= 1'b1;
            2'h2: begin
              if (is_cond) oe_n <= 1'b0;
              else if (is_stop) oe_n <= 1'b1;
              else if (bit_cnt != BYTE_BITS) sh <= {sh[6:0], sda_s};
              else ack_in <= ~sda_s;
            end
            2'h3: begin
              if (!is_stop) scl <= 1'b0;
              if (is_byte && bit_cnt != BYTE_BITS) bit_cnt <= bit_cnt + 4'h1;
              if (phase_end) begin
                phase   <= eff_next;
                bit_cnt <= 4'h0;
                sh      <= next_sh;
                if (phase == P_DATA || is_rx) remain <= remain - LEN_W'(1);
                if (is_rx) begin
                  rd_data  <= sh;
                  rd_valid <= 1'b1;
                end
                if (tx_nack) nack <= 1'b1;
                if (is_stop) begin
                  cmd_ready <= 1'b1;
                  done      <= 1'b1;
                end
              end
            end
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: link_checker.sv
`timescale 1ns/1ps
`default_nettype none

module link_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe_n,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // bus condition decode
  // ----------------------------------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic       busy;
  logic       seen;
  logic [3:0] rises;
  wire        start_det = scl && scl_q && sda_q && !sda;
  wire        stop_det  = scl && scl_q && !sda_q && sda;
  wire        scl_rise  = scl && !scl_q;

  // frame flag, scl rises in the byte, first slave drive of the frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy  <= 1'b0;
      seen  <= 1'b0;
      rises <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      busy  <= start_det ? 1'b1 : (stop_det ? 1'b0 : busy);
      seen  <= start_det ? 1'b0 : (seen || !d_sda_oe_n);
      rises <= start_det ? 4'h0 : (scl_rise ? ((rises == 4'h9) ? 4'h1 : rises + 4'h1) : rises);
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_stable_scl_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe_n))
    else $error("slave changed sda while scl high");
  chk_open_drain: assert property (!d_sda_oe_n || !m_sda_oe_n |-> !sda && !d_sda_o && !m_sda_o)
    else $error("driven sda not low");
  chk_reset_release: assert property ($rose(rst_n) |-> d_sda_oe_n && m_sda_oe_n && scl)
    else $error("bus not released after reset");
  chk_idle_quiet: assert property (!busy |-> d_sda_oe_n)
    else $error("slave drives sda outside a frame");
  chk_drive_in_low: assert property ($fell(d_sda_oe_n) |-> !scl [*8])
    else $error("slave began driving late in scl low phase");
  chk_addr_ack_bit: assert property ($fell(d_sda_oe_n) && !seen |-> rises == 4'h8)
    else $error("first slave drive not at ninth bit");
  chk_scl_idle_high: assert property (!busy && !$past(busy) |-> scl)
    else $error("scl low on idle bus");
  chk_ack_held: assert property ($rose(scl) && !d_sda_oe_n |-> !d_sda_oe_n [*8])
    else $error("slave drive dropped during scl high");

  cov_start: cover property ($rose(busy));
  cov_addr_ack: cover property ($fell(d_sda_oe_n) && rises == 4'h8);
  cov_stop: cover property ($fell(busy));
endmodule

`default_nettype wire

// file: i2c_serial_eeprom_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_serial_eeprom_slave_bench;
  import eeprom_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int F_RDY = 0, F_DONE = 1, F_WR = 2, F_BUSY = 3;
  logic             clk;
  logic             rst_n;
  logic             sup_reset;
  logic             prog_busy;
  logic             cmd_valid;
  logic             cmd_ready;
  op_t              cmd_op;
  logic [7:0]       cmd_addr;
  logic [LEN_W-1:0] cmd_len;
  logic             wr_valid;
  logic             wr_ready;
  logic [7:0]       wr_data;
  logic             rd_valid;
  logic [7:0]       rd_data;
  logic             done;
  logic             nack;
  logic [3:0]       flags;
  logic [31:0]      lfsr;
  logic [7:0]       b0;
  logic [7:0]       mem [256];
  logic [7:0]       expq [$];
  int               n_fail;
  int               comparisons;

  assign flags = {prog_busy, wr_ready, done, cmd_ready};

  i2c_if i2c_if_i ();
  // programming outlasts the first poll's start but ends before the second poll's start
  eeprom_slave #(.WR_CYCLES(1500)) eeprom_slave_i (.clk(clk), .rst_n(rst_n), .sup_reset(sup_reset),
    .bus(i2c_if_i), .prog_busy(prog_busy));
  eeprom_master eeprom_master_i (.clk(clk), .rst_n(rst_n), .bus(i2c_if_i), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
  link_checker link_checker_i (.clk(clk), .rst_n(rst_n), .scl(i2c_if_i.scl), .m_sda_o(i2c_if_i.m_sda_o),
    .m_sda_oe_n(i2c_if_i.m_sda_oe_n), .d_sda_o(i2c_if_i.d_sda_o), .d_sda_oe_n(i2c_if_i.d_sda_oe_n),
    .sda(i2c_if_i.sda));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // bounded wait on a status flag, sampled at falling edges
  task automatic wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (flags[k] !== v) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        check(1'b0, "wait ran out");
        end_sim();
      end
    end
  endtask

  // random bytes into the write fifo, noted in the expected array
  task automatic push(input logic [7:0] a, input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      lfsr = step(lfsr);
      b = lfsr[7:0];
      mem[{a[7:4], a[3:0] + i[3:0]}] = b;
      @(negedge clk);
      wait_for(F_WR, 1'b1);
      wr_data = b;
      wr_valid = 1'b1;
      @(negedge clk);
      wr_valid = 1'b0;
    end
  endtask

  task automatic run(input op_t op, input logic [7:0] a, input int n, input logic exp_nack);
    @(negedge clk);
    wait_for(F_RDY, 1'b1);
    cmd_op = op;
    cmd_addr = a;
    cmd_len = n[LEN_W-1:0];
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_for(F_DONE, 1'b1);
    check(nack === exp_nack, "nack flag");
  endtask

  // notes expected bytes, address counter steps over all bits
  task automatic rd(input op_t op, input logic [7:0] a, input int n);
    logic [7:0] p;
    p = a;
    for (int i = 0; i < n; i++) begin
      expq.push_back(mem[p]);
      p = p + 8'h01;
    end
    run(op, a, n, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // clock, read monitor, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compares each read byte with the oldest note
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0)
        check(1'b0, "unexpected read byte");
      else
        check(rd_data === expq.pop_front(), "read data");
    end
  end

  initial begin
    lfsr = 32'h4F6879C3;
    n_fail = 0;
    comparisons = 0;
    rst_n = 1'b0;
    sup_reset = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_WRITE;
    cmd_addr = 8'h00;
    cmd_len = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check(cmd_ready === 1'b1 && wr_ready === 1'b1 && prog_busy === 1'b0, "reset values");
    push(8'hFF, 4);
    @(negedge clk);
    check(wr_ready === 1'b0, "fifo not full");
    run(OP_WRITE, 8'hFF, 4, 1'b0);
    check(prog_busy === 1'b1, "no programming after stop");
    run(OP_POLL, 8'h00, 1, 1'b1);
    run(OP_POLL, 8'h00, 1, 1'b0);
    push(8'h00, 2);
    run(OP_WRITE, 8'h00, 2, 1'b0);
    wait_for(F_BUSY, 1'b0);
    // supervisor reset in the data byte: no ack, no programming
    b0 = mem[8'h00];
    push(8'h00, 1);
    mem[8'h00] = b0;
    fork
      run(OP_WRITE, 8'h00, 1, 1'b1);
      begin
        repeat (5500) @(negedge clk);
        sup_reset = 1'b1;
      end
    join
    check(prog_busy === 1'b0, "aborted write programmed");
    run(OP_POLL, 8'h00, 1, 1'b1);
    sup_reset = 1'b0;
    repeat (10) @(negedge clk);
    rd(OP_READ_RAND, 8'hF0, 3);
    rd(OP_READ_RAND, 8'hFF, 1);
    rd(OP_READ_CUR, 8'h00, 2);
    check(expq.size() == 0, "read bytes missing");
    end_sim();
  end
endmodule

`default_nettype wire
